// File: rtl/uart_host_port.sv
// host parallel port, modem pins and channel interrupts of a dual uart
// assumes host pins are asynchronous; serial engine signals share clk
//
// Behaviour
// - clear to send gates transmit only with auto flag
// - clear to send readable in modem status bit 4
// - eight bit tristate host bus, all bits in parallel
// - data set ready reflected in modem status
// - control bit 0 one drives terminal ready low
// - interrupt high, driven only when control bit 3
// - interrupt outputs high impedance after reset
// - interrupt from rx, tx, errors, modem change
// - read strobe fall puts selected register on bus
// - write strobe rise captures bus into register
//
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
module uart_host_port (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [2:0] addr,
    input  wire logic       chan_a_select_n,
    input  wire logic       chan_b_select_n,
    input  wire logic       read_strobe_n,
    input  wire logic       write_strobe_n,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    input  wire logic       clear_to_send_in_a,
    input  wire logic       clear_to_send_in_b,
    input  wire logic       set_ready_in_a,
    input  wire logic       set_ready_in_b,
    output logic            terminal_ready_out_a,
    output logic            terminal_ready_out_b,
    output logic            irq_out_a,
    output logic            irq_oe_a,
    output logic            irq_out_b,
    output logic            irq_oe_b,
    input  wire logic [7:0] rx_data_a,
    input  wire logic [7:0] rx_data_b,
    input  wire logic       rx_avail_a,
    input  wire logic       rx_avail_b,
    input  wire logic       rx_error_a,
    input  wire logic       rx_error_b,
    input  wire logic       tx_space_a,
    input  wire logic       tx_space_b,
    output logic            tx_permit_a,
    output logic            tx_permit_b,
    output logic      [7:0] tx_data,
    output logic            tx_load_a,
    output logic            tx_load_b
);
    typedef struct packed {
        logic                  rd1, rd2, rd3;
        logic                  wr1, wr2, wr3;
        logic [1:0]            cs1, cs2;
        logic [2:0]            ad1, ad2;
        logic [7:0]            din1, din2;
        logic [1:0]            cts1, cts2, cts3;
        logic [1:0]            dsr1, dsr2, dsr3;
        uart_port_pkg::rd_state_t st;
        logic [7:0]            dout;
        logic                  doe;
        logic [1:0][7:0]       irq_enable_reg, enhanced_feature_reg, modem_control_reg, scr;
        logic [1:0][1:0]       delta;
        logic [1:0]            irq, irq_oe, dtr_n, tx_ok, tx_load;
        logic [7:0]            txd;
    } state_t;

    state_t q_r;
    state_t q_nxt;

    logic [1:0][7:0] rx_data;
    logic [1:0]      rx_avail, rx_error, tx_space;
    logic            rd_fall, wr_rise;

    assign rx_data  = {rx_data_b, rx_data_a};
    assign rx_avail = {rx_avail_b, rx_avail_a};
    assign rx_error = {rx_error_b, rx_error_a};
    assign tx_space = {tx_space_b, tx_space_a};
    assign rd_fall  = q_r.rd3 & ~q_r.rd2;
    assign wr_rise  = ~q_r.wr3 & q_r.wr2;

    // byte shown to the host for one channel at one offset
    function automatic logic [7:0] reg_read(input state_t s, input logic [7:0] rxd,
                                            input int ch);
        logic [7:0] v;
        v = 8'h00;
        case (s.ad2)
            uart_port_pkg::OFS_DATA: v = rxd;
            uart_port_pkg::OFS_IER:  v = s.irq_enable_reg[ch];
            uart_port_pkg::OFS_EFR:  v = s.enhanced_feature_reg[ch];
            uart_port_pkg::OFS_MCR:  v = s.modem_control_reg[ch];
            uart_port_pkg::OFS_MSR: begin
                v[uart_port_pkg::MSR_CTS]  = ~s.cts2[ch];
                v[uart_port_pkg::MSR_DSR]  = ~s.dsr2[ch];
                v[uart_port_pkg::MSR_DCTS] = s.delta[ch][0];
                v[uart_port_pkg::MSR_DDSR] = s.delta[ch][1];
            end
            uart_port_pkg::OFS_SCR:  v = s.scr[ch];
            default:                 v = 8'h00;
        endcase
        return v;
    endfunction : reg_read

    always_comb begin
        q_nxt = q_r;
        // two flops on every host and modem pin before use
        q_nxt.rd1  = read_strobe_n;
        q_nxt.rd2  = q_r.rd1;
        q_nxt.rd3  = q_r.rd2;
        q_nxt.wr1  = write_strobe_n;
        q_nxt.wr2  = q_r.wr1;
        q_nxt.wr3  = q_r.wr2;
        q_nxt.cs1  = {chan_b_select_n, chan_a_select_n};
        q_nxt.cs2  = q_r.cs1;
        q_nxt.ad1  = addr;
        q_nxt.ad2  = q_r.ad1;
        q_nxt.din1 = data_in;
        q_nxt.din2 = q_r.din1;
        q_nxt.cts1 = {clear_to_send_in_b, clear_to_send_in_a};
        q_nxt.cts2 = q_r.cts1;
        q_nxt.cts3 = q_r.cts2;
        q_nxt.dsr1 = {set_ready_in_b, set_ready_in_a};
        q_nxt.dsr2 = q_r.dsr1;
        q_nxt.dsr3 = q_r.dsr2;
        q_nxt.tx_load = 2'h0;

        // read side: channel a wins if the host selects both
        case (q_r.st)
            uart_port_pkg::RD_IDLE: begin
                q_nxt.doe = 1'b0;
                if (rd_fall && (q_r.cs2 != 2'h3)) begin
                    q_nxt.dout = q_r.cs2[0] ? reg_read(q_r, rx_data[1], 1)
                                            : reg_read(q_r, rx_data[0], 0);
                    q_nxt.doe  = 1'b1;
                    q_nxt.st   = uart_port_pkg::RD_DRIVE;
                end
            end
            uart_port_pkg::RD_DRIVE: begin
                if (q_r.rd2 || (q_r.cs2 == 2'h3)) begin
                    q_nxt.doe = 1'b0;
                    q_nxt.st  = uart_port_pkg::RD_IDLE;
                end
            end
            default: begin
                q_nxt.doe = 1'b0;
                q_nxt.st  = uart_port_pkg::RD_IDLE;
            end
        endcase

        for (int ch = 0; ch < uart_port_pkg::NCH; ch++) begin
            // status read clears deltas; a change in the same cycle still sets
            if (rd_fall && !q_r.cs2[ch] && (ch == 0 || q_r.cs2[0])
                && q_r.ad2 == uart_port_pkg::OFS_MSR) begin
                q_nxt.delta[ch] = 2'h0;
            end
            if (q_r.cts2[ch] != q_r.cts3[ch]) begin
                q_nxt.delta[ch][0] = 1'b1;
            end
            if (q_r.dsr2[ch] != q_r.dsr3[ch]) begin
                q_nxt.delta[ch][1] = 1'b1;
            end
            // data taken from the sample aligned with the strobe rise
            if (wr_rise && !q_r.cs2[ch]) begin
                case (q_r.ad2)
                    uart_port_pkg::OFS_DATA: begin
                        q_nxt.txd         = q_r.din2;
                        q_nxt.tx_load[ch] = 1'b1;
                    end
                    uart_port_pkg::OFS_IER: q_nxt.irq_enable_reg[ch] = q_r.din2;
                    uart_port_pkg::OFS_EFR: q_nxt.enhanced_feature_reg[ch] = q_r.din2;
                    uart_port_pkg::OFS_MCR: q_nxt.modem_control_reg[ch] = q_r.din2;
                    uart_port_pkg::OFS_SCR: q_nxt.scr[ch] = q_r.din2;
                    default: q_nxt.scr[ch] = q_r.scr[ch];
                endcase
            end
            q_nxt.dtr_n[ch]  = ~q_nxt.modem_control_reg[ch][uart_port_pkg::MCR_DTR];
            q_nxt.irq_oe[ch] = q_nxt.modem_control_reg[ch][uart_port_pkg::MCR_IRQ_EN];
            q_nxt.irq[ch] =
                (q_r.irq_enable_reg[ch][uart_port_pkg::IER_RX] & rx_avail[ch]) |
                (q_r.irq_enable_reg[ch][uart_port_pkg::IER_TX] & tx_space[ch]) |
                (q_r.irq_enable_reg[ch][uart_port_pkg::IER_LS] & rx_error[ch]) |
                (q_r.irq_enable_reg[ch][uart_port_pkg::IER_MS] & (|q_r.delta[ch]));
            // low clear to send permits; ignored without the auto flag
            q_nxt.tx_ok[ch] = ~q_r.enhanced_feature_reg[ch][uart_port_pkg::EFR_AUTO_CTS] | ~q_r.cts2[ch];
        end

        if (srst) begin
            q_nxt = '0;
            q_nxt.rd1  = 1'b1;
            q_nxt.rd2  = 1'b1;
            q_nxt.rd3  = 1'b1;
            q_nxt.wr1  = 1'b1;
            q_nxt.wr2  = 1'b1;
            q_nxt.wr3  = 1'b1;
            q_nxt.cs1  = 2'h3;
            q_nxt.cs2  = 2'h3;
            q_nxt.cts1 = 2'h3;
            q_nxt.cts2 = 2'h3;
            q_nxt.cts3 = 2'h3;
            q_nxt.dsr1 = 2'h3;
            q_nxt.dsr2 = 2'h3;
            q_nxt.dsr3 = 2'h3;
            q_nxt.st   = uart_port_pkg::RD_IDLE;
            q_nxt.dout = uart_port_pkg::BUS_RST;
            q_nxt.irq_enable_reg  = {2{uart_port_pkg::REG_RST}};
            q_nxt.enhanced_feature_reg  = {2{uart_port_pkg::REG_RST}};
            q_nxt.modem_control_reg  = {2{uart_port_pkg::REG_RST}};
            q_nxt.scr  = {2{uart_port_pkg::REG_RST}};
            q_nxt.dtr_n = 2'h3;
            q_nxt.tx_ok = 2'h3;
        end
    end

    always_ff @(posedge clk) begin
        q_r <= q_nxt;
    end

    assign data_out             = q_r.dout;
    assign data_oe              = q_r.doe;
    assign terminal_ready_out_a = q_r.dtr_n[0];
    assign terminal_ready_out_b = q_r.dtr_n[1];
    assign irq_out_a            = q_r.irq[0];
    assign irq_oe_a             = q_r.irq_oe[0];
    assign irq_out_b            = q_r.irq[1];
    assign irq_oe_b             = q_r.irq_oe[1];
    assign tx_permit_a          = q_r.tx_ok[0];
    assign tx_permit_b          = q_r.tx_ok[1];
    assign tx_data              = q_r.txd;
    assign tx_load_a            = q_r.tx_load[0];
    assign tx_load_b            = q_r.tx_load[1];

    logic wr_a, rd_a;
    assign wr_a = wr_rise & ~q_r.cs2[0];
    assign rd_a = rd_fall & ~q_r.cs2[0];
    // channel b write edge, so its control bit 0 is watched too
    logic wr_b;
    assign wr_b = wr_rise & ~q_r.cs2[1];

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_auto_cts_gate: assert property (
        (q_r.enhanced_feature_reg[0][uart_port_pkg::EFR_AUTO_CTS] && q_r.cts2[0]) |=> !tx_permit_a)
        else $error("transmit permitted while clear to send high");
    chk_cts_ignored: assert property (
        !q_r.enhanced_feature_reg[0][uart_port_pkg::EFR_AUTO_CTS] |=> tx_permit_a)
        else $error("transmit blocked without auto flag");
    chk_msr_cts_bit: assert property (
        (rd_a && q_r.ad2 == uart_port_pkg::OFS_MSR) |=>
        data_out[uart_port_pkg::MSR_CTS] == !$past(q_r.cts2[0]))
        else $error("status bit 4 does not show clear to send");
    chk_scr_capture: assert property (
        (wr_a && q_r.ad2 == uart_port_pkg::OFS_SCR) |=> q_r.scr[0] == $past(q_r.din2))
        else $error("write byte not captured");
    chk_dsr_delta: assert property (
        (q_r.dsr2[0] != q_r.dsr3[0]) |=> q_r.delta[0][1])
        else $error("set ready change not flagged");
    chk_dtr_drive: assert property (
        (wr_a && q_r.ad2 == uart_port_pkg::OFS_MCR) |=>
        terminal_ready_out_a == !$past(q_r.din2[uart_port_pkg::MCR_DTR]))
        else $error("terminal ready does not follow control bit 0");
    chk_irq_enable: assert property (
        $rose(irq_oe_a) |-> $past(wr_a && q_r.ad2 == uart_port_pkg::OFS_MCR))
        else $error("interrupt driven without control write");
    chk_irq_source: assert property (
        (q_r.irq_enable_reg[0][uart_port_pkg::IER_RX] && rx_avail_a) |=> irq_out_a)
        else $error("enabled receive data gave no interrupt");
    chk_read_drive: assert property (
        (rd_fall && q_r.cs2 != 2'h3 && q_r.st == uart_port_pkg::RD_IDLE) |=> data_oe)
        else $error("read strobe did not drive bus");
    chk_bus_release: assert property (
        (q_r.rd2 && q_r.rd3) |=> !data_oe)
        else $error("bus driven with no read");
    chk_b_cts_ignored: assert property (
        !q_r.enhanced_feature_reg[1][uart_port_pkg::EFR_AUTO_CTS]
        |=> tx_permit_b)
        else $error("channel b transmit blocked without auto flag");
    chk_cts_delta: assert property (
        (q_r.cts2[0] != q_r.cts3[0])
        |=> q_r.delta[0][0])
        else $error("clear to send change not flagged");
    chk_delta_clear: assert property (
        (rd_a && q_r.ad2 == uart_port_pkg::OFS_MSR && q_r.cts2[0] == q_r.cts3[0]
         && q_r.dsr2[0] == q_r.dsr3[0]) |=> q_r.delta[0] == 2'h0)
        else $error("status read left a change flag set");
    chk_msr_dsr_bit: assert property (
        (rd_a && q_r.ad2 == uart_port_pkg::OFS_MSR) |=>
        data_out[uart_port_pkg::MSR_DSR] == !$past(q_r.dsr2[0]))
        else $error("status bit 5 does not show set ready");
    chk_data_load: assert property (
        (wr_a && q_r.ad2 == uart_port_pkg::OFS_DATA) |=>
        (tx_load_a && tx_data == $past(q_r.din2)))
        else $error("data byte not handed to transmitter");
    chk_b_dtr_drive: assert property (
        (wr_b && q_r.ad2 == uart_port_pkg::OFS_MCR) |=>
        terminal_ready_out_b == !$past(q_r.din2[uart_port_pkg::MCR_DTR]))
        else $error("channel b terminal ready does not follow control bit 0");
    chk_irq_oe_follow: assert property (
        (wr_a && q_r.ad2 == uart_port_pkg::OFS_MCR) |=>
        irq_oe_a == $past(q_r.din2[uart_port_pkg::MCR_IRQ_EN]))
        else $error("interrupt drive does not follow control bit 3");
    chk_err_irq: assert property (
        (q_r.irq_enable_reg[0][uart_port_pkg::IER_LS] && rx_error_a)
        |=> irq_out_a)
        else $error("enabled receive error gave no interrupt");
endmodule : uart_host_port

// File: rtl/uart_port_pkg.sv
// constants for the dual channel host port and modem pin block
// assumes one 100 MHz clock and a synchronous active-high reset
package uart_port_pkg;
    localparam int NCH = 2;
    // register offsets on the three address pins
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IER  = 3'h1;
    localparam logic [2:0] OFS_EFR  = 3'h2;
    localparam logic [2:0] OFS_MCR  = 3'h4;
    localparam logic [2:0] OFS_MSR  = 3'h6;
    localparam logic [2:0] OFS_SCR  = 3'h7;
    // field positions
    localparam int MCR_DTR      = 0;
    localparam int MCR_IRQ_EN   = 3;
    localparam int EFR_AUTO_CTS = 7;
    localparam int MSR_DCTS     = 0;
    localparam int MSR_DDSR     = 1;
    localparam int MSR_CTS      = 4;
    localparam int MSR_DSR      = 5;
    localparam int IER_RX       = 0;
    localparam int IER_TX       = 1;
    localparam int IER_LS       = 2;
    localparam int IER_MS       = 3;
    // reset values
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] BUS_RST = 8'h00;
    typedef enum logic [1:0] {
        RD_IDLE  = 2'h1,
        RD_DRIVE = 2'h2
    } rd_state_t;
endpackage : uart_port_pkg

// File: tb/modem_model.sv
// modem side model: active-low clear to send and data set ready lines
// assumes the bench sets the two request flags right after a clock edge
`timescale 1ns/10ps
module modem_model (
    input  wire logic cts_on,
    input  wire logic dsr_on,
    output logic      clear_to_send_in_a,
    output logic      set_ready_in_a
);
    // lines are low while the modem asserts them
    assign clear_to_send_in_a = !cts_on;
    assign set_ready_in_a     = !dsr_on;
endmodule : modem_model

// File: tb/test_uart_host_port.sv
// bench for the host port: pin-level bus tasks and a modem model
// assumes the design synchronises host pins to clk; channel b shares a lines
`timescale 1ns/10ps
module test_uart_host_port;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic       chan_a_select_n = 1'b1;
    logic       chan_b_select_n = 1'b1;
    logic       read_strobe_n = 1'b1;
    logic       write_strobe_n = 1'b1;
    logic [7:0] data_in = 8'h00;
    logic [7:0] rx_data_a = 8'h5a;
    logic       rx_avail_a = 1'b0;
    logic       rx_error_a = 1'b0;
    logic       tx_space_a = 1'b0;
    logic       cts_on = 1'b0;
    logic       dsr_on = 1'b0;
    logic [7:0] data_out, tx_data, rd;
    logic       data_oe, terminal_ready_out_a, terminal_ready_out_b, irq_out_a, irq_oe_a;
    logic       irq_out_b, irq_oe_b, tx_permit_a, tx_permit_b, tx_load_a, tx_load_b;
    logic       clear_to_send_in_a, set_ready_in_a;
    int         error_cnt = 0;
    int         checked = 0;
    int         loads = 0;
    int         loads_b = 0;
    always #5 clk = ~clk;
    always @(posedge clk) if (tx_load_a === 1'b1) loads <= loads + 1;
    always @(posedge clk) if (tx_load_b === 1'b1) loads_b <= loads_b + 1;
    uart_host_port uart_host_port_i (
        .clk, .srst, .addr, .chan_a_select_n, .chan_b_select_n, .read_strobe_n,
        .write_strobe_n, .data_in, .data_out, .data_oe, .clear_to_send_in_a,
        .clear_to_send_in_b(clear_to_send_in_a), .set_ready_in_a,
        .set_ready_in_b(set_ready_in_a), .terminal_ready_out_a, .terminal_ready_out_b,
        .irq_out_a, .irq_oe_a, .irq_out_b, .irq_oe_b, .rx_data_a, .rx_data_b(rx_data_a),
        .rx_avail_a, .rx_avail_b(rx_avail_a), .rx_error_a, .rx_error_b(rx_error_a),
        .tx_space_a, .tx_space_b(tx_space_a), .tx_permit_a, .tx_permit_b, .tx_data,
        .tx_load_a, .tx_load_b
    );
    modem_model modem_model_i (.cts_on, .dsr_on, .clear_to_send_in_a, .set_ready_in_a);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop
    // pins are synchronised, so everything is held three cycles around each edge
    task automatic sel(input logic [1:0] ch, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        chan_a_select_n <= !ch[0];
        chan_b_select_n <= !ch[1];
        addr <= a;
        data_in <= d;
        repeat (3) @(posedge clk);
    endtask : sel
    task automatic drop();
        repeat (4) @(posedge clk);
        chan_a_select_n <= 1'b1;
        chan_b_select_n <= 1'b1;
        #1;
    endtask : drop
    task automatic wr(input logic [1:0] ch, input logic [2:0] a, input logic [7:0] d);
        sel(ch, a, d);
        write_strobe_n <= 1'b0;
        repeat (4) @(posedge clk);
        write_strobe_n <= 1'b1;
        drop();
    endtask : wr
    task automatic wait_oe(input logic v);
        int n;
        n = 0;
        #1;
        while (data_oe !== v) begin
            if (n++ == 10) begin
                error_cnt++;
                report_and_stop();
            end
            @(posedge clk);
            #1;
        end
    endtask : wait_oe
    task automatic rd_reg(input logic [1:0] ch, input logic [2:0] a, output logic [7:0] q);
        sel(ch, a, 8'h00);
        read_strobe_n <= 1'b0;
        wait_oe(1'b1);
        q = data_out;
        @(posedge clk);
        read_strobe_n <= 1'b1;
        wait_oe(1'b0);
        drop();
    endtask : rd_reg
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        check(data_oe, 1'b0);
        check({irq_oe_a, irq_oe_b, irq_out_a}, 3'h0);
        check({terminal_ready_out_a, terminal_ready_out_b, tx_permit_a}, 3'h7);
        $display("test reset done");
        wr(2'b01, uart_port_pkg::OFS_MCR, 8'h01);
        check({terminal_ready_out_a, terminal_ready_out_b}, 2'b01);
        wr(2'b11, uart_port_pkg::OFS_MCR, 8'h00);
        check({terminal_ready_out_a, terminal_ready_out_b}, 2'b11);
        $display("test terminal ready done");
        wr(2'b10, uart_port_pkg::OFS_SCR, 8'h81);
        rd_reg(2'b10, uart_port_pkg::OFS_SCR, rd);
        check(rd, 8'h81);
        rd_reg(2'b01, uart_port_pkg::OFS_SCR, rd);
        check(rd, 8'h00);
        rd_reg(2'b01, 3'h5, rd);
        check(rd, 8'h00);
        wr(2'b01, uart_port_pkg::OFS_DATA, 8'h01);
        check(tx_data, 8'h01);
        check(8'(loads), 8'h01);
        check(8'(loads_b), 8'h00);
        wr(2'b10, uart_port_pkg::OFS_DATA, 8'hc3);
        check(tx_data, 8'hc3);
        check(8'(loads_b), 8'h01);
        check(8'(loads), 8'h01);
        rd_reg(2'b01, uart_port_pkg::OFS_DATA, rd);
        check(rd, 8'h5a);
        $display("test bus access done");
        @(posedge clk);
        cts_on <= 1'b1;
        dsr_on <= 1'b1;
        rd_reg(2'b01, uart_port_pkg::OFS_MSR, rd);
        check(rd, 8'h33);
        rd_reg(2'b01, uart_port_pkg::OFS_MSR, rd);
        check(rd, 8'h30);
        // raising clear to send only stops channel a, whose auto flag is set
        wr(2'b01, uart_port_pkg::OFS_EFR, 8'h80);
        check(tx_permit_a, 1'b1);
        @(posedge clk);
        cts_on <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check({tx_permit_a, tx_permit_b}, 2'b01);
        wr(2'b01, uart_port_pkg::OFS_EFR, 8'h00);
        check(tx_permit_a, 1'b1);
        rd_reg(2'b01, uart_port_pkg::OFS_MSR, rd);
        check(rd, 8'h21);
        $display("test modem lines done");
        wr(2'b01, uart_port_pkg::OFS_MCR, 8'h08);
        for (int i = 0; i < 4; i++) begin
            wr(2'b01, uart_port_pkg::OFS_IER, 8'h01 << i);
            check({irq_oe_a, irq_out_a, irq_oe_b, irq_out_b}, 4'b1000);
            @(posedge clk);
            case (i)
                0: rx_avail_a <= 1'b1;
                1: tx_space_a <= 1'b1;
                2: rx_error_a <= 1'b1;
                default: dsr_on <= 1'b0;
            endcase
            repeat (6) @(posedge clk);
            #1;
            check(irq_out_a, 1'b1);
            @(posedge clk);
            {rx_avail_a, tx_space_a, rx_error_a} <= 3'h0;
        end
        wr(2'b01, uart_port_pkg::OFS_MCR, 8'h00);
        check(irq_oe_a, 1'b0);
        $display("test interrupts done");
        report_and_stop();
    end
endmodule : test_uart_host_port
